// File: bench/aao_core_bench.sv
// Self-checking bench for the accumulator ALU core
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %h got %h", nm, e, g); end end
module aao_core_bench;
   localparam logic [31:0] nil = 32'h0000_0000;
   logic        CLK = 1'b0;
   logic        RST_N;
   logic        CE = 1'b1;
   logic [4:0]  AVS_ADDRESS = 5'h00;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = nil;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic [31:0] q;
   int          errors = 0;
   int          n_checks = 0;
   always #12.5 CLK = ~CLK;
   // Byte enables tied on: lane tests left out to fit the run
   aao_core aao_core_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE), .AVS_ADDRESS(AVS_ADDRESS),
      .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
      .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_WRITE <= w;
      AVS_READ <= !w;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      do begin
         @(posedge CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
      q = AVS_READDATA;
      if (n >= 100) errors++;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   // Vector: bit, imm, mem, work, expected mem, expected work, flags, expected flags
   task automatic alu(input aao_pkg::aao_op_t op, input logic [51:0] v);
      bus(1'b1, aao_pkg::REG_RPTR, 32'h0000_0002);
      bus(1'b1, aao_pkg::REG_RDATA, {24'h00_0000, v[39:32]});
      bus(1'b1, aao_pkg::REG_WORK, {24'h00_0000, v[31:24]});
      bus(1'b1, aao_pkg::REG_FLAGS, {28'h000_0000, v[7:4]});
      bus(1'b1, aao_pkg::REG_CMD, {2'b00, op, 5'h00, v[50:48], 8'h02, v[47:40]});
      bus(1'b0, aao_pkg::REG_RDATA, nil);
      `CHK("mem", v[23:16], q[7:0])
      bus(1'b0, aao_pkg::REG_WORK, nil);
      `CHK("work", v[15:8], q[7:0])
      bus(1'b0, aao_pkg::REG_FLAGS, nil);
      `CHK("flags", v[3:0], q[3:0])
   endtask
   task automatic t_arith;
      alu(aao_pkg::OP_PLUS_TO_WORKING, 52'h0_0088_7888_0007);
      alu(aao_pkg::OP_MINUS_INTO_RAM, 52'h0_0020_10F0_1001);
      alu(aao_pkg::OP_MINUS_WITH_BORROW_TO_WORKING, 52'h0_0000_8000_7F1A);
      alu(aao_pkg::OP_MINUS_WITH_BORROW_INTO_RAM, 52'h0_0001_0503_0510);
      alu(aao_pkg::OP_MINUS_IMM_TO_WORKING, 52'h0_0500_0500_0014);
   endtask
   task automatic t_logic;
      alu(aao_pkg::OP_CONJUNCTION_IMM, 52'h0_0F00_F000_0015);
      alu(aao_pkg::OP_EXCLUSIVE_DISJUNCTION_INTO_RAM, 52'h0_000F_F0FF_F0FB);
      alu(aao_pkg::OP_INVERT_TO_WORKING, 52'h0_00FF_12FF_0004);
      alu(aao_pkg::OP_MINUS_ONE_RAM, 52'h0_0000_12FF_1240);
      alu(aao_pkg::OP_BCD_FIXUP, 52'h0_0033_0F15_0FCC);
      alu(aao_pkg::OP_BCD_FIXUP, 52'h0_0033_A000_A001);
   endtask
   task automatic t_move;
      alu(aao_pkg::OP_TRANSFER_IMM_TO_WORKING, 52'h0_3C00_0000_3CFF);
      alu(aao_pkg::OP_TRANSFER_WORKING_TO_RAM, 52'h0_0000_5A5A_5A00);
      alu(aao_pkg::OP_CIRCULAR_RIGHT_TO_WORKING, 52'h0_0001_0001_80FF);
      alu(aao_pkg::OP_CIRCULAR_LEFT_VIA_CARRY, 52'h0_0081_0002_0001);
      alu(aao_pkg::OP_BIT_RAISE, 52'h7_0000_0080_0000);
      alu(aao_pkg::OP_BIT_LOWER, 52'h0_00FF_00FE_0000);
   endtask
   task automatic t_flow;
      bus(1'b1, aao_pkg::REG_TPTR, 32'h0000_0003);
      alu(aao_pkg::OP_TABLE_FETCH, 52'h0_0000_11FC_1100);
      bus(1'b0, aao_pkg::REG_THI, nil);
      `CHK("thi", 8'h59, q[7:0])
      bus(1'b1, aao_pkg::REG_PC, 32'h0000_0010);
      alu(aao_pkg::OP_SKIP_IF_BIT_SET, 52'h7_0080_0080_0000);
      bus(1'b0, aao_pkg::REG_PC, nil);
      `CHK("pc", 18'h0_0012, q[17:0])
      bus(1'b1, aao_pkg::REG_CMD, {2'b00, aao_pkg::OP_SUBROUTINE_CALL, 24'h00_0123});
      bus(1'b0, aao_pkg::REG_PC, nil);
      `CHK("pc", 18'h1_0123, q[17:0])
      bus(1'b1, aao_pkg::REG_CMD, {2'b00, aao_pkg::OP_SUBROUTINE_EXIT, 24'h00_0000});
      bus(1'b0, aao_pkg::REG_PC, nil);
      `CHK("pc", 18'h0_0013, q[17:0])
      bus(1'b1, aao_pkg::REG_CMD, {2'b00, aao_pkg::OP_GOTO_TARGET, 24'h00_0055});
      bus(1'b0, aao_pkg::REG_PC, nil);
      `CHK("pc", 18'h0_0055, q[17:0])
      CE <= 1'b0;
      fork
         bus(1'b1, aao_pkg::REG_WORK, 32'h0000_0033);
         begin
            repeat (9) @(posedge CLK);
            CE <= 1'b1;
         end
      join
      bus(1'b0, aao_pkg::REG_WORK, nil);
      `CHK("work", 8'h33, q[7:0])
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      RST_N <= 1'b0;
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      t_arith();
      t_logic();
      t_move();
      t_flow();
      end_sim();
   end
   // Whole run needs about 15 us
   initial begin
      #200000;
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire

// File: bench/aao_core_chk.sv
// Bus timing checks for the accumulator ALU core
`timescale 1ns/1ps
`default_nettype none
module aao_core_chk (
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        CE,
   input wire logic [4:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   aao_pkg::aao_op_t op;
   assign op = aao_pkg::aao_op_t'(AVS_WRITEDATA[29:24]);
   // Timing holds only while CE stays high
   a_cmd_one_icycle: assert property (CE && $rose(AVS_WRITE) && AVS_ADDRESS[4:2] == 3'h0 &&
      op < aao_pkg::OP_GOTO_TARGET |-> AVS_WAITREQUEST [*5] ##1 !AVS_WAITREQUEST)
      else $error("one-cycle command ack not after four clocks");
   a_cmd_two_icycle: assert property (CE && $rose(AVS_WRITE) && AVS_ADDRESS[4:2] == 3'h0 &&
      op inside {aao_pkg::OP_GOTO_TARGET, aao_pkg::OP_SUBROUTINE_CALL,
      aao_pkg::OP_SUBROUTINE_EXIT, aao_pkg::OP_TABLE_FETCH}
      |-> AVS_WAITREQUEST [*8] ##1 AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
      else $error("two-cycle command ack not after eight clocks");
   a_read_prompt: assert property (CE && $rose(AVS_READ) |-> ##1 !AVS_WAITREQUEST)
      else $error("read ack late");
   a_reg_write_prompt: assert property (CE && $rose(AVS_WRITE) && AVS_ADDRESS[4:2] != 3'h0
      |-> ##1 !AVS_WAITREQUEST) else $error("register write ack late");
   a_ack_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("ack longer than one cycle");
   a_no_idle_ack: assert property (!AVS_READ && !AVS_WRITE |-> AVS_WAITREQUEST)
      else $error("ack without request");
   a_rdata_hold: assert property ($changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
      else $error("read data moved outside a read ack");
   a_reset_quiet: assert property (disable iff (1'b0) !RST_N |-> AVS_WAITREQUEST &&
      AVS_READDATA == 32'h0000_0000) else $error("bus not quiet in reset");
   cover property ($rose(AVS_WRITE) && op == aao_pkg::OP_SUBROUTINE_CALL);
   cover property ($rose(AVS_WRITE) && op == aao_pkg::OP_BCD_FIXUP);
   cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind aao_core aao_core_chk aao_core_chk_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE),
   .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
`default_nettype wire

// File: hw/aao_core.sv
// Accumulator ALU core with data memory, sequencer and Avalon-MM slave
// Summary of operation
// RQ1: Three transfers: memory to working, working to memory, immediate to working.
// RQ2: Memory plus working in one cycle into working, updating Z, C, half, signed.
// RQ3: Carry takes the addition carry above 255 and the subtraction borrow.
// RQ4: Memory-destination subtracts write the difference back to memory, four flags updated.
// RQ5: Subtract-with-borrow also subtracts current carry; working or memory destination.
// RQ6: Immediate subtract in one cycle, result in working, four flags updated.
// RQ7: Decimal fixup corrects working after BCD add, result to memory, only carry.
// RQ8: AND, OR, XOR with memory or immediate, working or memory destination, Z only.
// RQ9: Logic result zero sets the zero flag, otherwise clears it.
// RQ10: Invert memory byte into memory or working, only zero flag.
// RQ11: Plus or minus one on memory byte into memory or working, only zero.
// RQ12: Plain rotates by one bit left or right, no flag change.
// RQ13: Rotates through carry as ninth bit, only carry changes.
// RQ14: Conditional skips test memory byte or bit, skipping the next instruction.
// RQ15: Call saves the following address; exit resumes there.
// RQ16: Jump loads the target without saving a return address.
// RQ17: Bit raise and lower change only the chosen bit by internal read-modify-write.
// RQ18: Bit index selects positions zero through seven.
// RQ19: Constant table in program memory fetched into data memory.
// RQ20: Each instruction cycle lasts four clocks.
// RQ21: Jump, call, exit, table fetch and taken skips take two cycles.
// RQ22: Half flag is carry or borrow out of bit three; signed flag is overflow.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module aao_core #(
   parameter int RAM_DEPTH   = 16,
   parameter int PC_W        = 12,
   parameter int STACK_DEPTH = 4
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        CE,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST
);

   localparam int RAM_AW = $clog2(RAM_DEPTH);
   localparam int SP_W   = $clog2(STACK_DEPTH);
   localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);
   localparam logic [PC_W-1:0] PC_TWO = PC_W'(2);
   localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

   typedef struct packed {
      aao_pkg::aao_state_t               st;
      logic [3:0]                        cnt;
      logic [31:0]                       cmd;
      logic [7:0]                        work;
      logic [3:0]                        flg;
      logic [PC_W-1:0]                   pc;
      logic [SP_W-1:0]                   sp;
      logic [STACK_DEPTH-1:0][PC_W-1:0]  stk;
      logic [RAM_DEPTH-1:0][7:0]         ram;
      logic [RAM_AW-1:0]                 rptr;
      logic [7:0]                        tptr;
      logic [7:0]                        thi;
      logic [31:0]                       rdata;
   } aao_regs_t;

   aao_regs_t s_r;
   aao_regs_t s_nxt;

   // Returns {signed, half, carry, sum}
   function automatic logic [10:0] aao_add(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin);
      logic [8:0] s;
      logic [4:0] n;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {(a[7] == b[7]) && (s[7] != a[7]), n[4], s[8], s[7:0]}; // RQ22
   endfunction

   // Returns {signed, half borrow, borrow, difference}
   function automatic logic [10:0] aao_sub(input logic [7:0] a, input logic [7:0] b,
                                           input logic bin);
      logic [8:0] d;
      logic [4:0] n;
      d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
      n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
      return {(a[7] != b[7]) && (d[7] != a[7]), n[4], d[8], d[7:0]}; // RQ22
   endfunction

   function automatic logic [31:0] aao_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Constant table contents are arbitrary
   function automatic logic [15:0] aao_table(input logic [7:0] idx);
      return {idx ^ 8'h5A, ~idx};
   endfunction

   always_comb begin
      aao_pkg::aao_op_t op;
      logic [7:0]       imm;
      logic [RAM_AW-1:0] ma;
      logic [2:0]       bi;
      logic [7:0]       m;
      logic [7:0]       a;
      logic             c;
      logic [7:0]       res;
      logic [10:0]      alu;
      logic [8:0]       t9;
      logic [15:0]      tw;
      logic [3:0]       fl;
      logic             wr_ram;
      logic             wr_work;
      logic             upd_z;
      logic             skip;
      logic             two;
      logic [4:0]       sel;
      logic [31:0]      wd;
      logic [31:0]      rd;
      s_nxt   = s_r;
      op      = aao_pkg::aao_op_t'(s_r.cmd[aao_pkg::CMD_OP_LSB +: 6]);
      imm     = s_r.cmd[aao_pkg::CMD_IMM_LSB +: 8];
      ma      = s_r.cmd[aao_pkg::CMD_ADDR_LSB +: RAM_AW];
      bi      = s_r.cmd[aao_pkg::CMD_BIT_LSB +: 3]; // RQ18
      m       = s_r.ram[ma];
      a       = s_r.work;
      c       = s_r.flg[aao_pkg::FLG_C];
      res     = a;
      alu     = 11'h000;
      t9      = 9'h000;
      tw      = aao_table(s_r.tptr);
      fl      = s_r.flg;
      wr_ram  = 1'b0;
      wr_work = 1'b0;
      upd_z   = 1'b0;
      skip    = 1'b0;
      two     = 1'b0;
      sel     = {AVS_ADDRESS[4:2], 2'b00};
      wd      = 32'h0000_0000;
      rd      = 32'h0000_0000;

      case (op)
         aao_pkg::OP_TRANSFER_RAM_TO_WORKING: begin
            res     = m; // RQ1
            wr_work = 1'b1;
         end
         aao_pkg::OP_TRANSFER_WORKING_TO_RAM: begin
            res    = a; // RQ1
            wr_ram = 1'b1;
         end
         aao_pkg::OP_TRANSFER_IMM_TO_WORKING: begin
            res     = imm; // RQ1
            wr_work = 1'b1;
         end
         aao_pkg::OP_PLUS_TO_WORKING, aao_pkg::OP_PLUS_INTO_RAM,
         aao_pkg::OP_PLUS_IMM_TO_WORKING, aao_pkg::OP_PLUS_WITH_CARRY_TO_WORKING,
         aao_pkg::OP_PLUS_WITH_CARRY_INTO_RAM: begin
            alu = aao_add(a, (op == aao_pkg::OP_PLUS_IMM_TO_WORKING) ? imm : m,
                          c && (op == aao_pkg::OP_PLUS_WITH_CARRY_TO_WORKING ||
                                op == aao_pkg::OP_PLUS_WITH_CARRY_INTO_RAM)); // RQ2
            wr_ram  = (op == aao_pkg::OP_PLUS_INTO_RAM) ||
                      (op == aao_pkg::OP_PLUS_WITH_CARRY_INTO_RAM);
            wr_work = !wr_ram;
         end
         aao_pkg::OP_MINUS_IMM_TO_WORKING, aao_pkg::OP_MINUS_TO_WORKING,
         aao_pkg::OP_MINUS_INTO_RAM, aao_pkg::OP_MINUS_WITH_BORROW_TO_WORKING,
         aao_pkg::OP_MINUS_WITH_BORROW_INTO_RAM: begin
            alu = aao_sub(a, (op == aao_pkg::OP_MINUS_IMM_TO_WORKING) ? imm : m, // RQ6
                          c && (op == aao_pkg::OP_MINUS_WITH_BORROW_TO_WORKING ||
                                op == aao_pkg::OP_MINUS_WITH_BORROW_INTO_RAM)); // RQ5
            wr_ram  = (op == aao_pkg::OP_MINUS_INTO_RAM) ||
                      (op == aao_pkg::OP_MINUS_WITH_BORROW_INTO_RAM); // RQ4
            wr_work = !wr_ram;
         end
         aao_pkg::OP_BCD_FIXUP: begin
            t9 = {1'b0, a};
            if (a[3:0] > 4'h9 || s_r.flg[aao_pkg::FLG_H]) begin
               t9 = t9 + 9'h006;
            end
            if (t9[8] || t9[7:4] > 4'h9 || c) begin
               t9 = t9 + 9'h060;
            end
            res             = t9[7:0]; // RQ7
            fl[aao_pkg::FLG_C] = t9[8] || c; // RQ7
            wr_ram          = 1'b1;
         end
         aao_pkg::OP_CONJUNCTION_TO_WORKING, aao_pkg::OP_CONJUNCTION_INTO_RAM,
         aao_pkg::OP_CONJUNCTION_IMM: begin
            res     = a & ((op == aao_pkg::OP_CONJUNCTION_IMM) ? imm : m); // RQ8
            wr_ram  = (op == aao_pkg::OP_CONJUNCTION_INTO_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_DISJUNCTION_TO_WORKING, aao_pkg::OP_DISJUNCTION_INTO_RAM,
         aao_pkg::OP_DISJUNCTION_IMM: begin
            res     = a | ((op == aao_pkg::OP_DISJUNCTION_IMM) ? imm : m); // RQ8
            wr_ram  = (op == aao_pkg::OP_DISJUNCTION_INTO_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_EXCL_DISJUNCTION_TO_WORKING, aao_pkg::OP_EXCLUSIVE_DISJUNCTION_INTO_RAM,
         aao_pkg::OP_EXCL_DISJUNCTION_IMM: begin
            res     = a ^ ((op == aao_pkg::OP_EXCL_DISJUNCTION_IMM) ? imm : m); // RQ8
            wr_ram  = (op == aao_pkg::OP_EXCLUSIVE_DISJUNCTION_INTO_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_INVERT_RAM, aao_pkg::OP_INVERT_TO_WORKING: begin
            res     = ~m; // RQ10
            wr_ram  = (op == aao_pkg::OP_INVERT_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_PLUS_ONE_RAM, aao_pkg::OP_PLUS_ONE_TO_WORKING: begin
            res     = m + 8'h01; // RQ11
            wr_ram  = (op == aao_pkg::OP_PLUS_ONE_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_MINUS_ONE_RAM, aao_pkg::OP_MINUS_ONE_TO_WORKING: begin
            res     = m - 8'h01; // RQ11
            wr_ram  = (op == aao_pkg::OP_MINUS_ONE_RAM);
            wr_work = !wr_ram;
            upd_z   = 1'b1;
         end
         aao_pkg::OP_CIRCULAR_RIGHT, aao_pkg::OP_CIRCULAR_RIGHT_TO_WORKING: begin
            res     = {m[0], m[7:1]}; // RQ12
            wr_ram  = (op == aao_pkg::OP_CIRCULAR_RIGHT);
            wr_work = !wr_ram;
         end
         aao_pkg::OP_CIRCULAR_LEFT, aao_pkg::OP_CIRCULAR_LEFT_TO_WORKING: begin
            res     = {m[6:0], m[7]}; // RQ12
            wr_ram  = (op == aao_pkg::OP_CIRCULAR_LEFT);
            wr_work = !wr_ram;
         end
         aao_pkg::OP_CIRCULAR_RIGHT_VIA_CARRY,
         aao_pkg::OP_CIRCULAR_RIGHT_VIA_CARRY_TO_WORKING: begin
            res                = {c, m[7:1]}; // RQ13
            fl[aao_pkg::FLG_C] = m[0];
            wr_ram             = (op == aao_pkg::OP_CIRCULAR_RIGHT_VIA_CARRY);
            wr_work            = !wr_ram;
         end
         aao_pkg::OP_CIRCULAR_LEFT_VIA_CARRY,
         aao_pkg::OP_CIRCULAR_LEFT_VIA_CARRY_TO_WORKING: begin
            res                = {m[6:0], c}; // RQ13
            fl[aao_pkg::FLG_C] = m[7];
            wr_ram             = (op == aao_pkg::OP_CIRCULAR_LEFT_VIA_CARRY);
            wr_work            = !wr_ram;
         end
         aao_pkg::OP_GOTO_TARGET, aao_pkg::OP_SUBROUTINE_CALL,
         aao_pkg::OP_SUBROUTINE_EXIT: begin
            two = 1'b1; // RQ21
         end
         aao_pkg::OP_SKIP_IF_ZERO: begin
            skip = (m == 8'h00); // RQ14
         end
         aao_pkg::OP_SKIP_IF_BIT_ZERO: begin
            skip = !m[bi]; // RQ14
         end
         aao_pkg::OP_SKIP_IF_BIT_SET: begin
            skip = m[bi]; // RQ14
         end
         aao_pkg::OP_BIT_RAISE: begin
            res    = m | (8'h01 << bi); // RQ17
            wr_ram = 1'b1;
         end
         aao_pkg::OP_BIT_LOWER: begin
            res    = m & ~(8'h01 << bi); // RQ17
            wr_ram = 1'b1;
         end
         aao_pkg::OP_TABLE_FETCH: begin
            res    = tw[7:0]; // RQ19
            wr_ram = 1'b1;
            two    = 1'b1; // RQ21
         end
         default: begin
            res = a;
         end
      endcase

      if (alu != 11'h000 || (op >= aao_pkg::OP_PLUS_TO_WORKING &&
                             op <= aao_pkg::OP_MINUS_WITH_BORROW_INTO_RAM)) begin
         res                = alu[7:0];
         fl[aao_pkg::FLG_C] = alu[8]; // RQ3
         fl[aao_pkg::FLG_H] = alu[9]; // RQ22
         fl[aao_pkg::FLG_V] = alu[10]; // RQ22
         upd_z              = 1'b1;
      end
      if (upd_z) begin
         fl[aao_pkg::FLG_Z] = (res == 8'h00); // RQ9
      end

      case (sel)
         aao_pkg::REG_CMD:   rd = s_r.cmd;
         aao_pkg::REG_WORK:  rd = 32'(s_r.work);
         aao_pkg::REG_FLAGS: rd = 32'(s_r.flg);
         aao_pkg::REG_PC:    rd = 32'(s_r.pc) | (32'(s_r.sp) << aao_pkg::PC_SP_LSB);
         aao_pkg::REG_RPTR:  rd = 32'(s_r.rptr);
         aao_pkg::REG_RDATA: rd = 32'(s_r.ram[s_r.rptr]);
         aao_pkg::REG_TPTR:  rd = 32'(s_r.tptr);
         aao_pkg::REG_THI:   rd = 32'(s_r.thi);
         default:            rd = 32'h0000_0000;
      endcase

      case (s_r.st)
         aao_pkg::ST_IDLE: begin
            if (AVS_READ) begin
               s_nxt.rdata = rd;
               s_nxt.st    = aao_pkg::ST_ACK;
            end else if (AVS_WRITE) begin
               if (sel == aao_pkg::REG_CMD) begin
                  s_nxt.cmd = aao_merge(s_r.cmd, AVS_WRITEDATA, AVS_BYTEENABLE);
                  s_nxt.cnt = 4'h0;
                  s_nxt.st  = aao_pkg::ST_EXEC;
               end else begin
                  s_nxt.st = aao_pkg::ST_ACK;
               end
            end
         end
         aao_pkg::ST_EXEC: begin
            // Bus stays stalled, so operands cannot move under the instruction
            if (s_r.cnt == ((two || skip) ? aao_pkg::CNT_TWO : aao_pkg::CNT_ONE)) begin // RQ20
               s_nxt.st  = aao_pkg::ST_ACK;
               s_nxt.flg = fl;
               if (wr_work) begin
                  s_nxt.work = res;
               end
               if (wr_ram) begin
                  s_nxt.ram[ma] = res;
               end
               if (op == aao_pkg::OP_TABLE_FETCH) begin
                  s_nxt.thi = tw[15:8]; // RQ19
               end
               case (op)
                  aao_pkg::OP_GOTO_TARGET: begin
                     s_nxt.pc = s_r.cmd[PC_W-1:0]; // RQ16
                  end
                  aao_pkg::OP_SUBROUTINE_CALL: begin
                     s_nxt.stk[s_r.sp] = s_r.pc + PC_ONE; // RQ15
                     s_nxt.sp          = s_r.sp + SP_ONE;
                     s_nxt.pc          = s_r.cmd[PC_W-1:0];
                  end
                  aao_pkg::OP_SUBROUTINE_EXIT: begin
                     // Stack wraps when over- or underrun, as in a small hardware stack
                     s_nxt.sp = s_r.sp - SP_ONE; // RQ15
                     s_nxt.pc = s_r.stk[s_r.sp - SP_ONE];
                  end
                  default: begin
                     s_nxt.pc = s_r.pc + (skip ? PC_TWO : PC_ONE); // RQ14
                  end
               endcase
            end else begin
               s_nxt.cnt = s_r.cnt + 4'h1;
            end
         end
         aao_pkg::ST_ACK: begin
            s_nxt.st = aao_pkg::ST_IDLE;
            if (AVS_WRITE && sel != aao_pkg::REG_CMD) begin
               wd = AVS_WRITEDATA;
               case (sel)
                  aao_pkg::REG_WORK:
                     s_nxt.work = 8'(aao_merge(32'(s_r.work), wd, AVS_BYTEENABLE));
                  aao_pkg::REG_FLAGS: begin
                     if (AVS_BYTEENABLE[0]) begin
                        s_nxt.flg = wd[3:0];
                     end
                  end
                  aao_pkg::REG_PC: begin
                     rd       = aao_merge(32'(s_r.pc), wd, AVS_BYTEENABLE);
                     s_nxt.pc = rd[PC_W-1:0];
                  end
                  aao_pkg::REG_RPTR: begin
                     if (AVS_BYTEENABLE[0]) begin
                        s_nxt.rptr = wd[RAM_AW-1:0];
                     end
                  end
                  aao_pkg::REG_RDATA: begin
                     if (AVS_BYTEENABLE[0]) begin
                        s_nxt.ram[s_r.rptr] = wd[7:0];
                     end
                  end
                  aao_pkg::REG_TPTR: begin
                     if (AVS_BYTEENABLE[0]) begin
                        s_nxt.tptr = wd[7:0];
                     end
                  end
                  default: begin
                     s_nxt.st = aao_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            s_nxt.st = aao_pkg::ST_IDLE;
         end
      endcase

      if (!CE) begin
         s_nxt = s_r;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign AVS_READDATA    = s_r.rdata;
   assign AVS_WAITREQUEST = (s_r.st != aao_pkg::ST_ACK) || !CE;

endmodule

`default_nettype wire

// File: hw/aao_pkg.sv
// Constants, opcodes and states of the accumulator ALU core
package aao_pkg;

   // Register byte offsets
   localparam logic [4:0] REG_CMD   = 5'h00;
   localparam logic [4:0] REG_WORK  = 5'h04;
   localparam logic [4:0] REG_FLAGS = 5'h08;
   localparam logic [4:0] REG_PC    = 5'h0C;
   localparam logic [4:0] REG_RPTR  = 5'h10;
   localparam logic [4:0] REG_RDATA = 5'h14;
   localparam logic [4:0] REG_TPTR  = 5'h18;
   localparam logic [4:0] REG_THI   = 5'h1C;

   // Command word fields, and stack pointer position in the PC register
   localparam int CMD_IMM_LSB  = 0;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_BIT_LSB  = 16;
   localparam int CMD_OP_LSB   = 24;
   localparam int PC_SP_LSB    = 16;

   // Flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_H = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_V = 3;

   // Reset values
   localparam logic [31:0] CMD_RST  = 32'h0000_0000;
   localparam logic [7:0]  BYTE_RST = 8'h00;
   localparam logic [3:0]  FLG_RST  = 4'h0;

   // Timing: one instruction cycle is four clocks
   localparam int         CLK_PER_ICYCLE = 4;
   localparam logic [3:0] CNT_ONE = 4'(CLK_PER_ICYCLE - 1);
   localparam logic [3:0] CNT_TWO = 4'(2 * CLK_PER_ICYCLE - 1);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_ACK  = 2'b10
   } aao_state_t;

   typedef enum logic [5:0] {
      OP_NOP                          = 6'b000000,
      OP_TRANSFER_RAM_TO_WORKING      = 6'b000001,
      OP_TRANSFER_WORKING_TO_RAM      = 6'b000010,
      OP_TRANSFER_IMM_TO_WORKING      = 6'b000011,
      OP_PLUS_TO_WORKING              = 6'b000100,
      OP_PLUS_INTO_RAM                = 6'b000101,
      OP_PLUS_IMM_TO_WORKING          = 6'b000110,
      OP_PLUS_WITH_CARRY_TO_WORKING   = 6'b000111,
      OP_PLUS_WITH_CARRY_INTO_RAM     = 6'b001000,
      OP_MINUS_IMM_TO_WORKING         = 6'b001001,
      OP_MINUS_TO_WORKING             = 6'b001010,
      OP_MINUS_INTO_RAM               = 6'b001011,
      OP_MINUS_WITH_BORROW_TO_WORKING = 6'b001100,
      OP_MINUS_WITH_BORROW_INTO_RAM   = 6'b001101,
      OP_BCD_FIXUP                    = 6'b001110,
      OP_CONJUNCTION_TO_WORKING       = 6'b001111,
      OP_DISJUNCTION_TO_WORKING       = 6'b010000,
      OP_EXCL_DISJUNCTION_TO_WORKING  = 6'b010001,
      OP_CONJUNCTION_INTO_RAM         = 6'b010010,
      OP_DISJUNCTION_INTO_RAM         = 6'b010011,
      OP_EXCLUSIVE_DISJUNCTION_INTO_RAM = 6'b010100,
      OP_CONJUNCTION_IMM              = 6'b010101,
      OP_DISJUNCTION_IMM              = 6'b010110,
      OP_EXCL_DISJUNCTION_IMM         = 6'b010111,
      OP_INVERT_RAM                   = 6'b011000,
      OP_INVERT_TO_WORKING            = 6'b011001,
      OP_PLUS_ONE_TO_WORKING          = 6'b011010,
      OP_PLUS_ONE_RAM                 = 6'b011011,
      OP_MINUS_ONE_TO_WORKING         = 6'b011100,
      OP_MINUS_ONE_RAM                = 6'b011101,
      OP_CIRCULAR_RIGHT_TO_WORKING    = 6'b011110,
      OP_CIRCULAR_RIGHT               = 6'b011111,
      OP_CIRCULAR_RIGHT_VIA_CARRY_TO_WORKING = 6'b100000,
      OP_CIRCULAR_RIGHT_VIA_CARRY     = 6'b100001,
      OP_CIRCULAR_LEFT_TO_WORKING     = 6'b100010,
      OP_CIRCULAR_LEFT                = 6'b100011,
      OP_CIRCULAR_LEFT_VIA_CARRY_TO_WORKING = 6'b100100,
      OP_CIRCULAR_LEFT_VIA_CARRY      = 6'b100101,
      OP_GOTO_TARGET                  = 6'b100110,
      OP_SUBROUTINE_CALL              = 6'b100111,
      OP_SUBROUTINE_EXIT              = 6'b101000,
      OP_SKIP_IF_ZERO                 = 6'b101001,
      OP_SKIP_IF_BIT_ZERO             = 6'b101010,
      OP_SKIP_IF_BIT_SET              = 6'b101011,
      OP_BIT_RAISE                    = 6'b101100,
      OP_BIT_LOWER                    = 6'b101101,
      OP_TABLE_FETCH                  = 6'b101110
   } aao_op_t;

endpackage

// File: hw/placeholder_unused_removed.sv
// Intentionally holds no module; keeps no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
